// ==== common/ifec_pkg.sv ====
// Purpose: Constants and state layout for the interrupt flag/enable core
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, 8-bit registers
// Notes:   Register offsets and reset values live here; the core spells out some bit positions
package ifec_pkg;

   // **********
   // Register byte offsets
   // **********
   localparam logic [4:0] IFEC_OFF_CTL_PRIMARY = 5'h00;
   localparam logic [4:0] IFEC_OFF_CTL_EDGES   = 5'h04;
   localparam logic [4:0] IFEC_OFF_CTL_PINS    = 5'h08;
   localparam logic [4:0] IFEC_OFF_PFLAGS_ONE  = 5'h0C;
   localparam logic [4:0] IFEC_OFF_PFLAGS_TWO  = 5'h10;
   localparam logic [4:0] IFEC_OFF_PFLAGS_THR  = 5'h14;
   localparam logic [4:0] IFEC_OFF_RESET_CTL   = 5'h18;

   // **********
   // Reset values
   // **********
   localparam logic [7:0] IFEC_RST_CTL_PRIMARY = 8'h00;
   localparam logic [7:0] IFEC_RST_CTL_EDGES   = 8'hFF;
   localparam logic [7:0] IFEC_RST_CTL_PINS    = 8'hC0;
   localparam logic [7:0] IFEC_RST_PFLAGS      = 8'h00;
   localparam logic [7:0] IFEC_RST_RESET_CTL   = 8'h00;
   localparam logic [1:0] IFEC_SYNC_FILL       = 2'h3;

   // **********
   // Implemented bit masks of the flag registers
   // **********
   localparam logic [7:0] IFEC_MASK_PF1 = 8'hFF;
   localparam logic [7:0] IFEC_MASK_PF2 = 8'h5F;
   localparam logic [7:0] IFEC_MASK_PF3 = 8'h3F;
   localparam logic [7:0] IFEC_RO_PF1   = 8'h30;
   localparam logic [7:0] IFEC_RO_PF3   = 8'h30;

   // **********
   // Field positions
   // **********
   localparam int IFEC_B_GLOBAL_HIGH  = 7;
   localparam int IFEC_B_PERIPH_LOW   = 6;
   localparam int IFEC_B_T0_EN        = 5;
   localparam int IFEC_B_PIN0_EN      = 4;
   localparam int IFEC_B_PCHG_EN      = 3;
   localparam int IFEC_B_T0_FLAG      = 2;
   localparam int IFEC_B_PIN0_FLAG    = 1;
   localparam int IFEC_B_PCHG_FLAG    = 0;
   localparam int IFEC_B_PULLUP_DIS   = 7;
   localparam int IFEC_B_EDGE0        = 6;
   localparam int IFEC_B_T0_PRI       = 2;
   localparam int IFEC_B_PIN3_PRI     = 1;
   localparam int IFEC_B_PCHG_PRI     = 0;
   localparam int IFEC_B_PIN2_PRI     = 7;
   localparam int IFEC_B_PIN1_PRI     = 6;
   localparam int IFEC_B_PIN1_EN      = 3;
   localparam int IFEC_B_PIN1_FLAG    = 0;
   localparam int IFEC_B_PRIO_MODE    = 7;

   // **********
   // Whole state of the block
   // **********
   typedef struct packed {
      logic [7:0]  ctl_primary;
      logic [7:0]  ctl_edges;
      logic [7:0]  ctl_pins;
      logic [7:0]  pflags_one;
      logic [7:0]  pflags_two;
      logic [7:0]  pflags_thr;
      logic [7:0]  reset_ctl;
      logic [3:0]  pin_s1;
      logic [3:0]  pin_s2;
      logic [3:0]  pin_prev;
      logic [3:0]  pb_s1;
      logic [3:0]  pb_s2;
      logic [3:0]  pb_last;
      logic [1:0]  primed;
      logic        waitreq;
      logic [31:0] rdata;
      logic        irq_high;
      logic        irq_low;
      logic [7:0]  pullup_en;
   } ifec_state_s;

endpackage

// ==== design/ifec_core.sv ====
// Purpose: Interrupt enables, edge selects, priorities and request flags
// Assumes: Event inputs are one-cycle pulses on sys_clk; pins are async
// Notes:   Avalon-MM slave answers every access two edges after request
//
// How it works
// - Flags set on their events regardless of any enable bit.
// - Bit 7 is global enable, or high-priority enable in priority mode.
// - Bit 6 enables peripherals, or all low-priority ones in priority mode.
// - Enables for timer0, pin0, port change; pins 1-3 in third register.
// - Timer0 overflow sets bit 2; only software clears it.
// - Each external pin edge sets its flag; software write clears it.
// - Port-change flag keeps setting until port B is read.
// - Pull-up disable kills all pull-ups, else each follows its latch.
// - Edge select 1 means rising edge, 0 means falling edge.
// - Priority bit 1 marks high priority, 0 low priority.
// - Pin 1 and 2 priorities sit in bits 6, 7 and reset high.
// - Parallel port access sets its flag; software clears it.
// - Conversion done sets converter flag until software clears it.
// - Receive flag is read-only and mirrors receive buffer full.
// - Transmit flag is read-only and mirrors transmit buffer empty.
// - Sync serial done and bus collision set flags; software clears.
// - First capture/compare flag set on timer1 capture or match.
// - Capture/compare 2-5 flags set on their capture or match.
// - Timer2 match and timer1/timer3 overflows set flags.
// - Timer1 overflow flag is bit 0 of first register, resets 0.
// - Timer4 flag is bit 3 of third register, software clears.
// - Low-voltage detect sets its flag until software clears.
// - Priority mode bit 7 of reset control, off by default.
// - Flag, enable and global enable raise high or low request.
// - Accepting an interrupt clears the global enable that allowed it.
`timescale 1ns/1ps

module ifec_core
   import ifec_pkg::*;
#(
   parameter int ADDR_W = 5
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Pins, asynchronous
   input  wire logic [3:0]  ext_pin,
   input  wire logic [3:0]  port_b_pins,
   // Port B side
   input  wire logic        port_b_read,
   input  wire logic [7:0]  port_b_latch,
   output logic [7:0]       pullup_en,
   // Peripheral events, one-cycle pulses
   input  wire logic        timer0_ovf,
   input  wire logic        psp_access,
   input  wire logic        conv_done,
   input  wire logic        sync_serial_done,
   input  wire logic        capcmp1_event,
   input  wire logic        timer2_match,
   input  wire logic        timer1_ovf,
   input  wire logic        comparator_change,
   input  wire logic        nv_write_done,
   input  wire logic        bus_collision,
   input  wire logic        low_voltage,
   input  wire logic        timer3_ovf,
   input  wire logic        capcmp2_event,
   input  wire logic        timer4_event,
   input  wire logic [2:0]  capcmp3to5_event,
   // Serial buffer levels
   input  wire logic        serial1_rx_full,
   input  wire logic        serial1_tx_empty,
   input  wire logic        serial2_rx_full,
   input  wire logic        serial2_tx_empty,
   // Peripheral enables and priorities, flag-register layout
   input  wire logic [23:0] periph_enable,
   input  wire logic [23:0] periph_priority,
   // Processor core side
   input  wire logic        irq_ack,
   input  wire logic        irq_ack_high,
   output logic             irq_high,
   output logic             irq_low
);

   // **********
   // Elaboration checks
   // **********
   if (ADDR_W < 5) begin : g_addr_check
      $error("ADDR_W must be at least 5");
   end

   // **********
   // Functions
   // **********
   // Any source pending whose priority matches the wanted level
   function automatic logic any_pending(
      input logic [23:0] flags,
      input logic [23:0] ens,
      input logic [23:0] pris,
      input logic        use_pri,
      input logic        want_high
   );
      logic [23:0] hit;
      hit = flags & ens;
      if (use_pri) begin
         hit = want_high ? (hit & pris) : (hit & ~pris);
      end
      return |hit;
   endfunction

   // Software value merged with hardware sets; set wins over clear
   function automatic logic [7:0] merge_flags(
      input logic [7:0] cur,
      input logic       wr,
      input logic [7:0] wval,
      input logic [7:0] sets,
      input logic [7:0] mask
   );
      logic [7:0] v;
      v = wr ? wval : cur;
      return (v | sets) & mask;
   endfunction

   // **********
   // State
   // **********
   ifec_state_s st_reg;
   ifec_state_s st_next;

   logic        accept;
   logic        wr_hit;
   logic [4:0]  waddr;
   logic [7:0]  wbyte;
   logic [3:0]  edge_hit;
   logic [3:0]  pb_mismatch;
   logic [7:0]  pf1_set;
   logic [7:0]  pf2_set;
   logic [7:0]  pf3_set;
   logic [7:0]  ctl1_set;
   logic [7:0]  ctl3_set;
   logic [23:0] pflags_all;
   logic [23:0] core_flags;
   logic [23:0] core_ens;
   logic [23:0] core_pris;
   logic        prio_mode;
   logic        core_hi;
   logic        core_lo;
   logic        per_hi;
   logic        per_lo;
   logic [7:0]  rd_byte;

   // Request taken at the edge where waitrequest is already low
   assign accept = (read | write) & ~st_reg.waitreq;
   assign wr_hit = accept & write & byteenable[0];
   assign waddr  = address[4:0];
   assign wbyte  = writedata[7:0];

   // **********
   // Next-state logic
   // **********
   always_comb begin
      st_next = st_reg;

      // Two-stage synchronisers; stage one feeds only stage two
      st_next.pin_s1   = ext_pin;
      st_next.pin_s2   = st_reg.pin_s1;
      st_next.pin_prev = st_reg.pin_s2;
      st_next.pb_s1    = port_b_pins;
      st_next.pb_s2    = st_reg.pb_s1;

      // Edge selects per pin, rising when the bit is high
      edge_hit[0] = st_reg.ctl_edges[IFEC_B_EDGE0]
                  ? (st_reg.pin_s2[0] & ~st_reg.pin_prev[0])
                  : (~st_reg.pin_s2[0] & st_reg.pin_prev[0]);
      for (int i = 1; i < 4; i++) begin
         edge_hit[i] = st_reg.ctl_edges[IFEC_B_EDGE0 - i]
                     ? (st_reg.pin_s2[i] & ~st_reg.pin_prev[i])
                     : (~st_reg.pin_s2[i] & st_reg.pin_prev[i]);
      end

      // Idle-high pins fake nothing: wait until synchronisers are full
      if (st_reg.primed != IFEC_SYNC_FILL) begin
         st_next.primed = st_reg.primed + 2'h1;
         edge_hit       = 4'h0;
      end
      if (st_reg.primed != IFEC_SYNC_FILL || port_b_read) begin
         st_next.pb_last = st_reg.pb_s2;
      end
      pb_mismatch = (st_reg.primed == IFEC_SYNC_FILL && !port_b_read)
                  ? (st_reg.pb_s2 ^ st_reg.pb_last) : 4'h0;

      // Hardware sets of the core flags, enables ignored
      ctl1_set = 8'h00;
      ctl1_set[IFEC_B_T0_FLAG]   = timer0_ovf;
      ctl1_set[IFEC_B_PIN0_FLAG] = edge_hit[0];
      ctl1_set[IFEC_B_PCHG_FLAG] = |pb_mismatch;
      ctl3_set = {5'h00, edge_hit[3:1]};

      // Peripheral flag sets
      pf1_set = {psp_access, conv_done, 2'b00, sync_serial_done,
                 capcmp1_event, timer2_match, timer1_ovf};
      pf2_set = {1'b0, comparator_change, 1'b0, nv_write_done,
                 bus_collision, low_voltage, timer3_ovf, capcmp2_event};
      pf3_set = {4'h0, timer4_event, capcmp3to5_event};

      // Control registers
      if (wr_hit && waddr == IFEC_OFF_CTL_EDGES) begin
         st_next.ctl_edges = wbyte;
      end
      if (wr_hit && waddr == IFEC_OFF_RESET_CTL) begin
         st_next.reset_ctl = wbyte & 8'h80;
      end
      st_next.ctl_primary = merge_flags(st_reg.ctl_primary,
         wr_hit && waddr == IFEC_OFF_CTL_PRIMARY, wbyte, ctl1_set,
         8'hFF);
      st_next.ctl_pins = merge_flags(st_reg.ctl_pins,
         wr_hit && waddr == IFEC_OFF_CTL_PINS, wbyte, ctl3_set,
         8'hFF);

      // Flag registers; read-only bits mirror the buffer levels
      st_next.pflags_one = merge_flags(st_reg.pflags_one,
         wr_hit && waddr == IFEC_OFF_PFLAGS_ONE, wbyte, pf1_set,
         IFEC_MASK_PF1 & ~IFEC_RO_PF1);
      st_next.pflags_one[5] = serial1_rx_full;
      st_next.pflags_one[4] = serial1_tx_empty;
      st_next.pflags_two = merge_flags(st_reg.pflags_two,
         wr_hit && waddr == IFEC_OFF_PFLAGS_TWO, wbyte, pf2_set,
         IFEC_MASK_PF2);
      st_next.pflags_thr = merge_flags(st_reg.pflags_thr,
         wr_hit && waddr == IFEC_OFF_PFLAGS_THR, wbyte, pf3_set,
         IFEC_MASK_PF3 & ~IFEC_RO_PF3);
      st_next.pflags_thr[5] = serial2_rx_full;
      st_next.pflags_thr[4] = serial2_tx_empty;

      // Accept clears the enable that let the request through
      prio_mode = st_reg.reset_ctl[IFEC_B_PRIO_MODE];
      if (irq_ack) begin
         if (!prio_mode || irq_ack_high) begin
            st_next.ctl_primary[IFEC_B_GLOBAL_HIGH] = 1'b0;
         end else begin
            st_next.ctl_primary[IFEC_B_PERIPH_LOW] = 1'b0;
         end
      end

      // Core sources: pin0, timer0, port change, pins 1-3
      core_flags = {18'h0,
         st_reg.ctl_pins[2:0],
         st_reg.ctl_primary[IFEC_B_PCHG_FLAG],
         st_reg.ctl_primary[IFEC_B_T0_FLAG],
         st_reg.ctl_primary[IFEC_B_PIN0_FLAG]};
      core_ens = {18'h0,
         st_reg.ctl_pins[5:3],
         st_reg.ctl_primary[IFEC_B_PCHG_EN],
         st_reg.ctl_primary[IFEC_B_T0_EN],
         st_reg.ctl_primary[IFEC_B_PIN0_EN]};
      // Pin 0 has no priority bit and is always high
      core_pris = {18'h0,
         st_reg.ctl_edges[IFEC_B_PIN3_PRI],
         st_reg.ctl_pins[IFEC_B_PIN2_PRI],
         st_reg.ctl_pins[IFEC_B_PIN1_PRI],
         st_reg.ctl_edges[IFEC_B_PCHG_PRI],
         st_reg.ctl_edges[IFEC_B_T0_PRI],
         1'b1};
      pflags_all = {st_reg.pflags_thr, st_reg.pflags_two,
                    st_reg.pflags_one};

      // Priority bits only count in priority mode
      core_hi = any_pending(core_flags, core_ens, core_pris,
                            prio_mode, 1'b1);
      core_lo = any_pending(core_flags, core_ens, core_pris,
                            prio_mode, 1'b0);
      per_hi  = any_pending(pflags_all, periph_enable, periph_priority,
                            prio_mode, 1'b1);
      per_lo  = any_pending(pflags_all, periph_enable, periph_priority,
                            prio_mode, 1'b0);

      // Request to the high or the low vector
      if (!prio_mode) begin
         st_next.irq_high = st_reg.ctl_primary[IFEC_B_GLOBAL_HIGH]
            & (core_hi | (st_reg.ctl_primary[IFEC_B_PERIPH_LOW]
            & per_hi));
         st_next.irq_low  = 1'b0;
      end else begin
         st_next.irq_high = st_reg.ctl_primary[IFEC_B_GLOBAL_HIGH]
            & (core_hi | per_hi);
         st_next.irq_low  = st_reg.ctl_primary[IFEC_B_GLOBAL_HIGH]
            & st_reg.ctl_primary[IFEC_B_PERIPH_LOW]
            & (core_lo | per_lo);
      end
      // A request just accepted is dropped at once
      if (irq_ack) begin
         st_next.irq_high = 1'b0;
         st_next.irq_low  = 1'b0;
      end

      // Pull-ups follow the port latch unless disabled
      st_next.pullup_en = st_reg.ctl_edges[IFEC_B_PULLUP_DIS]
                        ? 8'h00 : port_b_latch;

      // Read mux; unmapped offsets read zero
      unique case (waddr)
         IFEC_OFF_CTL_PRIMARY: rd_byte = st_reg.ctl_primary;
         IFEC_OFF_CTL_EDGES:   rd_byte = st_reg.ctl_edges;
         IFEC_OFF_CTL_PINS:    rd_byte = st_reg.ctl_pins;
         IFEC_OFF_PFLAGS_ONE:  rd_byte = st_reg.pflags_one;
         IFEC_OFF_PFLAGS_TWO:  rd_byte = st_reg.pflags_two;
         IFEC_OFF_PFLAGS_THR:  rd_byte = st_reg.pflags_thr;
         IFEC_OFF_RESET_CTL:   rd_byte = st_reg.reset_ctl;
         default:              rd_byte = 8'h00;
      endcase

      // Bus handshake: one wait cycle, then answer, then idle high
      if ((read | write) && st_reg.waitreq) begin
         st_next.waitreq = 1'b0;
         st_next.rdata   = {24'h0, rd_byte};
      end else begin
         st_next.waitreq = 1'b1;
      end
   end

   // **********
   // State register
   // **********
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_reg             <= '0;
         st_reg.ctl_primary <= IFEC_RST_CTL_PRIMARY;
         st_reg.ctl_edges   <= IFEC_RST_CTL_EDGES;
         st_reg.ctl_pins    <= IFEC_RST_CTL_PINS;
         st_reg.pflags_one  <= IFEC_RST_PFLAGS;
         st_reg.pflags_two  <= IFEC_RST_PFLAGS;
         st_reg.pflags_thr  <= IFEC_RST_PFLAGS;
         st_reg.reset_ctl   <= IFEC_RST_RESET_CTL;
         st_reg.waitreq     <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // **********
   // Outputs, straight from the state register
   // **********
   assign readdata    = st_reg.rdata;
   assign waitrequest = st_reg.waitreq;
   assign irq_high    = st_reg.irq_high;
   assign irq_low     = st_reg.irq_low;
   assign pullup_en   = st_reg.pullup_en;

endmodule

// ==== tb/ifec_core_assertions.sv ====
// Purpose: Port-level checks of the core
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance
`timescale 1ns/1ps

module ifec_core_checker #(
   parameter int ADDR_W = 5
) (
   input logic              sys_clk,
   input logic              reset,
   input logic [ADDR_W-1:0] address,
   input logic              read,
   input logic              write,
   input logic [31:0]       readdata,
   input logic              waitrequest,
   input logic [7:0]        port_b_latch,
   input logic [7:0]        pullup_en,
   input logic              irq_ack,
   input logic              irq_high,
   input logic              irq_low
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   // One wait cycle, then a one-cycle answer
   a_wait_answer: assert property ((read || write) && waitrequest
      |=> !waitrequest) else $error("no answer");
   a_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("answer too long");
   a_wait_idle: assert property (!read && !write && waitrequest
      |=> waitrequest) else $error("answer without request");
   // Byte-wide registers
   a_rdata_upper: assert property (!waitrequest
      |-> readdata[31:8] == 24'h0) else $error("readdata upper set");
   a_rdata_hold: assert property (!read && !write
      |=> $stable(readdata)) else $error("readdata moved");
   // Nothing is mapped above the last register
   a_unmapped_zero: assert property (read && waitrequest
      && address > 5'h18 |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   // Pull-ups off, or the latch one cycle late
   a_pullup_src: assert property (pullup_en == 8'h00 ||
      pullup_en == $past(port_b_latch)) else $error("pull-up wrong");
   // Request drops right after an accept
   a_ack_drop: assert property (irq_ack
      |=> !irq_high && !irq_low) else $error("request after accept");
endmodule

bind ifec_core ifec_core_checker #(.ADDR_W(ADDR_W)) i_ifec_core_checker (
   .sys_clk(sys_clk), .reset(reset), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest),
   .port_b_latch(port_b_latch), .pullup_en(pullup_en),
   .irq_ack(irq_ack), .irq_high(irq_high), .irq_low(irq_low));

// ==== tb/ifec_core_partner.sv ====
// Purpose: Processor core model accepting requests
// Assumes: Requests drop the cycle after an accept
// Notes:   ack_delay sets how slowly the core answers
`timescale 1ns/1ps

module ifec_core_partner (
   input  logic       sys_clk,
   input  logic       reset,
   input  logic       irq_high,
   input  logic       irq_low,
   input  logic       ack_en,
   input  logic [3:0] ack_delay,
   output logic       irq_ack,
   output logic       irq_ack_high
);
   logic [3:0] wait_reg;

   // One pulse per request; vector line wanders while idle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wait_reg <= 4'h0;
         irq_ack <= 1'b0;
         irq_ack_high <= 1'b0;
      end else if (irq_ack) begin
         irq_ack <= 1'b0;
         wait_reg <= 4'h0;
      end else if (ack_en && (irq_high || irq_low)) begin
         if (wait_reg == ack_delay) begin
            irq_ack <= 1'b1;
            irq_ack_high <= irq_high;
         end else begin
            wait_reg <= wait_reg + 4'h1;
         end
      end else begin
         wait_reg <= 4'h0;
         irq_ack_high <= ~irq_ack_high;
      end
   end
endmodule

// ==== tb/tb_interrupt_flag_enable_core.sv ====
// Purpose: Self-checking bench of the core
// Assumes: One bus access at a time
// Notes:   Accepts come from the core model
`timescale 1ns/1ps

module tb_interrupt_flag_enable_core
   import ifec_pkg::*;
;
   logic        sys_clk, reset, read, write, port_b_read, ack_en;
   logic        irq_ack, irq_ack_high, irq_high, irq_low, waitrequest;
   logic [4:0]  address;
   logic [3:0]  ack_delay, ext_pin, port_b_pins, ser;
   logic [7:0]  port_b_latch, pullup_en;
   logic [16:0] ev;
   logic [23:0] p_en, p_pri;
   logic [31:0] writedata, readdata, q;
   int          mismatches, n_compared, cyc;

   ifec_core i_ifec_core (
      .sys_clk(sys_clk), .reset(reset), .address(address), .read(read),
      .write(write), .byteenable(4'hF), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .ext_pin(ext_pin),
      .port_b_pins(port_b_pins), .port_b_read(port_b_read),
      .port_b_latch(port_b_latch), .pullup_en(pullup_en),
      .timer0_ovf(ev[0]), .psp_access(ev[1]), .conv_done(ev[2]),
      .sync_serial_done(ev[3]), .capcmp1_event(ev[4]),
      .timer2_match(ev[5]), .timer1_ovf(ev[6]),
      .comparator_change(ev[7]), .nv_write_done(ev[8]),
      .bus_collision(ev[9]), .low_voltage(ev[10]), .timer3_ovf(ev[11]),
      .capcmp2_event(ev[12]), .timer4_event(ev[13]),
      .capcmp3to5_event(ev[16:14]), .serial1_rx_full(ser[0]),
      .serial1_tx_empty(ser[1]), .serial2_rx_full(ser[2]),
      .serial2_tx_empty(ser[3]), .periph_enable(p_en),
      .periph_priority(p_pri), .irq_ack(irq_ack),
      .irq_ack_high(irq_ack_high), .irq_high(irq_high), .irq_low(irq_low));

   ifec_core_partner i_ifec_core_partner (
      .sys_clk(sys_clk), .reset(reset), .irq_high(irq_high),
      .irq_low(irq_low), .ack_en(ack_en), .ack_delay(ack_delay),
      .irq_ack(irq_ack), .irq_ack_high(irq_ack_high));

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Hang guard, far above the run's length
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One access, held until waitrequest is low
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [7:0] d);
      @(posedge sys_clk);
      address <= a;
      writedata <= {24'h0, d};
      read <= !w;
      write <= w;
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e,
                     input string nm);
      bus(1'b0, a, 8'h00);
      chk(nm, q, {24'h0, e});
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic pulse(input logic [16:0] v);
      @(posedge sys_clk);
      ev <= v;
      @(posedge sys_clk);
      ev <= '0;
   endtask

   // Reset values and an unmapped offset
   task automatic t_reset();
      rd(IFEC_OFF_CTL_PRIMARY, IFEC_RST_CTL_PRIMARY, "prim");
      rd(IFEC_OFF_CTL_EDGES, IFEC_RST_CTL_EDGES, "edges");
      rd(IFEC_OFF_CTL_PINS, IFEC_RST_CTL_PINS, "pins");
      rd(IFEC_OFF_RESET_CTL, IFEC_RST_RESET_CTL, "rstctl");
      wr(5'h1C, 8'hFF);
      rd(5'h1C, 8'h00, "unmapped");
      $display("done: reset values");
   endtask

   // All event inputs fire, all enables off
   task automatic t_flags();
      pulse(17'h1FFFF);
      rd(IFEC_OFF_PFLAGS_ONE, 8'hCF, "flags1");
      rd(IFEC_OFF_PFLAGS_TWO, 8'h5F, "flags2");
      rd(IFEC_OFF_PFLAGS_THR, 8'h0F, "flags3");
      rd(IFEC_OFF_CTL_PRIMARY, 8'h04, "t0 flag");
      chk("irq_high", irq_high, 1'b0);
      wr(IFEC_OFF_PFLAGS_ONE, 8'h00);
      wr(IFEC_OFF_PFLAGS_TWO, 8'hFF);
      wr(IFEC_OFF_PFLAGS_THR, 8'hFF);
      rd(IFEC_OFF_PFLAGS_ONE, 8'h00, "flags1 clr");
      rd(IFEC_OFF_PFLAGS_TWO, 8'h5F, "flags2 ones");
      rd(IFEC_OFF_PFLAGS_THR, 8'h0F, "flags3 ones");
      wr(IFEC_OFF_PFLAGS_TWO, 8'h00);
      wr(IFEC_OFF_PFLAGS_THR, 8'h00);
      wr(IFEC_OFF_CTL_PRIMARY, 8'h00);
      $display("done: peripheral flags");
   endtask

   // Read-only serial flags follow buffer levels
   task automatic t_serial();
      ser <= 4'b0110;
      rd(IFEC_OFF_PFLAGS_ONE, 8'h10, "tx1 empty");
      wr(IFEC_OFF_PFLAGS_ONE, 8'h00);
      rd(IFEC_OFF_PFLAGS_ONE, 8'h10, "tx1 ro");
      rd(IFEC_OFF_PFLAGS_THR, 8'h20, "rx2 full");
      ser <= 4'b1001;
      rd(IFEC_OFF_PFLAGS_ONE, 8'h20, "rx1 full");
      rd(IFEC_OFF_PFLAGS_THR, 8'h10, "tx2 empty");
      ser <= 4'b0000;
      $display("done: serial flags");
   endtask

   // Pin edges of the selected sense only
   task automatic t_pins();
      ext_pin <= 4'hF;
      waitc(6);
      rd(IFEC_OFF_CTL_PRIMARY, 8'h02, "pin0 rise");
      rd(IFEC_OFF_CTL_PINS, 8'hC7, "pins rise");
      wr(IFEC_OFF_CTL_PRIMARY, 8'h00);
      wr(IFEC_OFF_CTL_PINS, 8'hF8);
      rd(IFEC_OFF_CTL_PINS, 8'hF8, "pin enables");
      wr(IFEC_OFF_CTL_EDGES, 8'h87);
      ext_pin <= 4'h0;
      waitc(6);
      rd(IFEC_OFF_CTL_PINS, 8'hFF, "pins fall");
      wr(IFEC_OFF_CTL_PRIMARY, 8'h00);
      wr(IFEC_OFF_CTL_PINS, 8'hC0);
      ext_pin <= 4'hF;
      waitc(6);
      rd(IFEC_OFF_CTL_PINS, 8'hC0, "rise ignored");
      wr(IFEC_OFF_CTL_EDGES, 8'hFF);
      $display("done: external pins");
   endtask

   // Port change keeps setting until port B is read
   task automatic t_port();
      port_b_pins <= 4'h5;
      waitc(6);
      rd(IFEC_OFF_CTL_PRIMARY, 8'h01, "pchg set");
      wr(IFEC_OFF_CTL_PRIMARY, 8'h00);
      rd(IFEC_OFF_CTL_PRIMARY, 8'h01, "pchg again");
      @(posedge sys_clk);
      port_b_read <= 1'b1;
      @(posedge sys_clk);
      port_b_read <= 1'b0;
      wr(IFEC_OFF_CTL_PRIMARY, 8'h00);
      rd(IFEC_OFF_CTL_PRIMARY, 8'h00, "pchg clr");
      $display("done: port change");
   endtask

   // Pull-ups off, then the latch
   task automatic t_pullup();
      port_b_latch <= 8'hA5;
      waitc(2);
      chk("pullup off", pullup_en, 8'h00);
      wr(IFEC_OFF_CTL_EDGES, 8'h7F);
      waitc(2);
      chk("pullup on", pullup_en, 8'hA5);
      wr(IFEC_OFF_CTL_EDGES, 8'hFF);
      $display("done: pull-ups");
   endtask

   // Mode off: global and peripheral enables
   task automatic t_irq_off();
      wr(IFEC_OFF_CTL_PRIMARY, 8'h20);
      pulse(17'h00001);
      waitc(3);
      chk("no global", irq_high, 1'b0);
      wr(IFEC_OFF_CTL_PRIMARY, 8'hA4);
      waitc(3);
      chk("t0 request", irq_high, 1'b1);
      ack_delay <= 4'h2;
      ack_en <= 1'b1;
      waitc(8);
      ack_en <= 1'b0;
      rd(IFEC_OFF_CTL_PRIMARY, 8'h24, "enable cleared");
      wr(IFEC_OFF_CTL_PRIMARY, 8'h00);
      p_en <= 24'h000001;
      pulse(17'h00040);
      wr(IFEC_OFF_CTL_PRIMARY, 8'h80);
      waitc(3);
      chk("periph masked", irq_high, 1'b0);
      wr(IFEC_OFF_CTL_PRIMARY, 8'hC0);
      waitc(3);
      chk("periph request", irq_high, 1'b1);
      chk("no low vector", irq_low, 1'b0);
      $display("done: compatibility mode");
   endtask

   // Priority mode: both groups, prompt accepts
   task automatic t_prio();
      wr(IFEC_OFF_RESET_CTL, 8'h80);
      wr(IFEC_OFF_CTL_PRIMARY, 8'h40);
      waitc(3);
      chk("low gated", irq_low, 1'b0);
      chk("not high", irq_high, 1'b0);
      wr(IFEC_OFF_CTL_PRIMARY, 8'h80);
      waitc(3);
      chk("low masked", irq_low, 1'b0);
      p_pri <= 24'h000001;
      waitc(3);
      chk("high request", irq_high, 1'b1);
      ack_delay <= 4'h0;
      ack_en <= 1'b1;
      waitc(6);
      ack_en <= 1'b0;
      rd(IFEC_OFF_CTL_PRIMARY, 8'h00, "high cleared");
      p_pri <= 24'h000000;
      wr(IFEC_OFF_CTL_PRIMARY, 8'hC0);
      waitc(3);
      chk("low vector", irq_low, 1'b1);
      ack_en <= 1'b1;
      waitc(6);
      ack_en <= 1'b0;
      rd(IFEC_OFF_CTL_PRIMARY, 8'h80, "low cleared");
      wr(IFEC_OFF_RESET_CTL, 8'h00);
      $display("done: priority mode");
   endtask

   initial begin
      {reset, read, write, port_b_read, ack_en} = 5'b10000;
      {address, writedata, ext_pin, port_b_pins, ser} = '0;
      {port_b_latch, ev, p_en, p_pri, ack_delay} = '0;
      {mismatches, n_compared, cyc} = '0;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_flags();
      t_serial();
      t_pins();
      t_port();
      t_pullup();
      t_irq_off();
      t_prio();
      finish_test();
   end
endmodule
